// *** rtl/cell_monitor_spi_host_port.sv ***
`timescale 1ns/100ps
// Behaviour
// - Serial slave only; host clocks up to 2 Mbps on its own serial clock.
// - Data output is high impedance whenever chip select is high.
// - Full duplex stand-alone, half duplex in daisy-chain mode.
// - Every byte moves most significant bit first, both directions.
// - Stand-alone length decided by first bit, then counting bytes.
// - Chip select high over 100 us resets state machine and counters.
// - Pending response goes out in first two bytes of a write; third discarded.
// - Half duplex: ready output low once a response byte is loaded.
// - Chip select rising after that byte releases ready and tri-states output.
// - While ready is low, input data is ignored; host drains first.
// - Ready is never asserted while chip select is already low.
// - Reads and actions are two bytes, writes three, responses two bytes.
// - Write: rw bit, 3-bit page, 6-bit location, 14-bit data.
// - Read: rw bit, page, location, six fill bits, then 16 returned bits.
// - Read value buffered, loaded at select, shifted out on falling edges.
// - Commands decode against pages 1 to 5 of 14-bit locations.
// - Non-writes are reads; writes get no response; unknown writes do nothing.
// - An unrecognised read returns 16'h0000.
// - Incomplete command counts as unrecognised; timeout resets the port.
// - Stand-alone: no CRC, no meaning for discovery or acknowledge commands.
module cell_monitor_spi_host_port #(
  parameter cell_monitor_spi_pkg::cnt_t TIMEOUT_CYCLES =
    cell_monitor_spi_pkg::cnt_t'(cell_monitor_spi_pkg::TIMEOUT_CYCLES)
) (
  // Core clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Host serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  output logic data_ready_n,
  // Configuration
  input wire logic daisy_mode,
  // Stand-alone memory access
  output logic acc_req,
  output logic acc_write,
  output logic [2:0] acc_page,
  output logic [5:0] acc_loc,
  output logic [13:0] acc_wdata,
  input wire logic [13:0] acc_rdata,
  input wire logic acc_hit,
  // Daisy-chain command and response bytes
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  output logic rsp_ready
);
  import cell_monitor_spi_pkg::*;

  typedef struct packed {
    logic cs_meta;
    logic cs_s;
    logic cs_d;
    logic tog_meta;
    logic tog_s;
    logic tog_d;
    frame_e st;
    logic [2:0] page;
    logic [5:0] loc;
    logic [5:0] dhi;
    logic [15:0] resp;
    logic [7:0] dz_byte;
    logic tx_mode;
    logic taken;
    logic ready_n;
    cnt_t hi_cnt;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic acc_req;
    logic acc_write;
    logic [2:0] acc_page;
    logic [5:0] acc_loc;
    logic [13:0] acc_wdata;
  } core_s;

  typedef struct packed {
    logic [6:0] sh;
    logic [2:0] cnt;
  } link_s;

  core_s s;
  core_s next_s;
  link_s l;
  link_s next_l;
  logic [7:0] rx_hold;
  logic rx_tog;
  logic [2:0] fall_cnt;
  logic byte_evt;
  logic timeout;
  logic [7:0] b;
  logic [7:0] tx_data;

  function automatic logic page_ok(input logic [2:0] p);
    page_ok = (p >= PAGE_FIRST) && (p <= PAGE_LAST);
  endfunction

  // Link side, serial clock domain; frame counters end with chip select
  always_comb
  begin
    next_l.sh = {l.sh[5:0], sdi};
    next_l.cnt = l.cnt + 3'd1;
  end

  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      l <= '0;
    else
      l <= next_l;
  end

  // Hold and toggle survive chip select so a byte ending at deselect is kept
  always_ff @(posedge sclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_hold <= FILL_BYTE;
      rx_tog <= 1'b0;
    end
    else if (!cs_n && l.cnt == 3'd7)
    begin
      rx_hold <= {l.sh, sdi};
      rx_tog <= ~rx_tog;
    end
  end

  // Output bit advances on falling edges, first bit valid at select
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
      fall_cnt <= 3'd0;
    else
      fall_cnt <= fall_cnt + 3'd1;
  end

  // Transmit byte changes only after a byte's last bit is sampled, so the link reads it stably
  assign tx_data = daisy_mode ? s.dz_byte : s.resp[15:8];
  assign sdo = tx_data[3'd7 - fall_cnt];
  // Half duplex lets the host tie data lines, so drive only in transmit mode
  assign sdo_oe = !cs_n && (!daisy_mode || s.tx_mode);
  assign data_ready_n = s.ready_n;
  assign rsp_ready = daisy_mode && s.ready_n && s.cs_s && s.cs_d;

  assign cmd_valid = s.cmd_valid;
  assign cmd_byte = s.cmd_byte;
  assign acc_req = s.acc_req;
  assign acc_write = s.acc_write;
  assign acc_page = s.acc_page;
  assign acc_loc = s.acc_loc;
  assign acc_wdata = s.acc_wdata;

  assign byte_evt = s.tog_s ^ s.tog_d;
  assign timeout = s.cs_s && (s.hi_cnt >= TIMEOUT_CYCLES);
  assign b = rx_hold;

  always_comb
  begin
    next_s = s;
    next_s.cs_meta = cs_n;
    next_s.cs_s = s.cs_meta;
    next_s.cs_d = s.cs_s;
    next_s.tog_meta = rx_tog;
    next_s.tog_s = s.tog_meta;
    next_s.tog_d = s.tog_s;
    next_s.cmd_valid = 1'b0;
    next_s.acc_req = 1'b0;
    if (!s.cs_s)
      next_s.hi_cnt = '0;
    else if (s.hi_cnt != '1)
      next_s.hi_cnt = s.hi_cnt + cnt_t'(1);
    // Map answers in the cycle the request stands
    if (s.acc_req && !s.acc_write)
      next_s.resp = acc_hit ? {RESP_PAD, acc_rdata} : UNKNOWN_READ;
    if (byte_evt && !daisy_mode)
    begin
      // Each byte exchanged moves the response one byte on
      next_s.resp = {s.resp[7:0], FILL_BYTE};
      case (s.st)
        st_first:
        begin
          next_s.page = b[PAGE_MSB:PAGE_LSB];
          next_s.loc = {b[LOC_HI_MSB:0], 2'b00};
          next_s.st = b[RW_POS] ? st_wr1 : st_rd;
        end
        st_rd:
        begin
          next_s.st = st_first;
          next_s.acc_loc = {s.loc[5:2], b[LOC_LO_MSB:LOC_LO_LSB]};
          next_s.acc_page = s.page;
          next_s.acc_write = 1'b0;
          if (page_ok(s.page))
            next_s.acc_req = 1'b1;
          else
            next_s.resp = UNKNOWN_READ;
        end
        st_wr1:
        begin
          next_s.loc = {s.loc[5:2], b[LOC_LO_MSB:LOC_LO_LSB]};
          next_s.dhi = b[DATA_HI_MSB:0];
          next_s.st = st_wr2;
        end
        default:
        begin
          next_s.st = st_first;
          next_s.acc_page = s.page;
          next_s.acc_loc = s.loc;
          next_s.acc_wdata = {s.dhi, b};
          next_s.acc_write = 1'b1;
          // Writes outside the map are dropped silently
          next_s.acc_req = page_ok(s.page);
        end
      endcase
    end
    // No CRC or acknowledge handling exists on this port
    if (byte_evt && daisy_mode && s.ready_n)
    begin
      next_s.cmd_valid = 1'b1;
      next_s.cmd_byte = b;
    end
    if (rsp_ready && rsp_valid)
    begin
      next_s.dz_byte = rsp_byte;
      next_s.ready_n = 1'b0;
      next_s.tx_mode = 1'b1;
    end
    if (!s.ready_n && !s.cs_s)
      next_s.taken = 1'b1;
    if (!s.ready_n && s.taken && s.cs_s)
    begin
      next_s.ready_n = 1'b1;
      next_s.tx_mode = 1'b0;
      next_s.taken = 1'b0;
    end
    // A pending daisy byte survives the timeout; only framing and the stand-alone response are cleared
    if (timeout)
    begin
      next_s.st = st_first;
      next_s.resp = UNKNOWN_READ;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= '0;
      s.cs_meta <= 1'b1;
      s.cs_s <= 1'b1;
      s.cs_d <= 1'b1;
      s.st <= st_first;
      s.resp <= UNKNOWN_READ;
      s.ready_n <= 1'b1;
    end
    else
      s <= next_s;
  end

  sdo_hiz_a: assert property (@(posedge clock) disable iff (!resetn)
    cs_n |-> !sdo_oe) else $error("data output driven while deselected");

  half_tx_a: assert property (@(posedge clock) disable iff (!resetn)
    daisy_mode && s.ready_n && !s.taken |-> !sdo_oe)
    else $error("half duplex output driven outside transmit mode");

  timeout_a: assert property (@(posedge clock) disable iff (!resetn)
    s.cs_s && s.hi_cnt == TIMEOUT_CYCLES |=> s.st == st_first && s.resp == UNKNOWN_READ)
    else $error("timeout did not reset the port");

  cnt_clear_a: assert property (@(posedge clock) disable iff (!resetn)
    !s.cs_s |=> s.hi_cnt == '0) else $error("high-time count not cleared");

  ready_set_a: assert property (@(posedge clock) disable iff (!resetn)
    rsp_valid && rsp_ready |=> !data_ready_n && s.dz_byte == $past(rsp_byte))
    else $error("response byte not announced");

  ready_cs_a: assert property (@(posedge clock) disable iff (!resetn)
    $fell(data_ready_n) |-> $past(s.cs_s, 1) && $past(s.cs_d, 1))
    else $error("ready asserted while selected");

  ready_rel_a: assert property (@(posedge clock) disable iff (!resetn)
    !data_ready_n && s.taken && s.cs_s |=> data_ready_n && !s.tx_mode)
    else $error("ready not released after byte read");

  ignore_in_a: assert property (@(posedge clock) disable iff (!resetn)
    !data_ready_n |=> !cmd_valid) else $error("input taken while ready low");

  unknown_rd_a: assert property (@(posedge clock) disable iff (!resetn)
    acc_req && !acc_write && !acc_hit |=> s.resp == UNKNOWN_READ)
    else $error("unrecognised read not zero");

  read_len_a: assert property (@(posedge clock) disable iff (!resetn)
    byte_evt && !daisy_mode && s.st == st_rd |=> s.st == st_first && acc_req == page_ok(s.page))
    else $error("read not closed after two bytes");

  write_len_a: assert property (@(posedge clock) disable iff (!resetn)
    byte_evt && !daisy_mode && s.st == st_wr1 |=> s.st == st_wr2 && !acc_req)
    else $error("write ended before third byte");

  page_range_a: assert property (@(posedge clock) disable iff (!resetn)
    acc_req |-> page_ok(acc_page)) else $error("access outside pages one to five");

  wr_fields_a: assert property (@(posedge clock) disable iff (!resetn)
    byte_evt && !daisy_mode && s.st == st_wr2 |=> acc_write && acc_loc == $past(s.loc)
    && acc_wdata == {$past(s.dhi), $past(b)} && acc_req == page_ok(acc_page))
    else $error("write fields not carried into the access");

  wr_quiet_a: assert property (@(posedge clock) disable iff (!resetn)
    byte_evt && !daisy_mode && s.st == st_wr2 |=> s.resp == '0)
    else $error("write left a response pending");

  resp_shift_a: assert property (@(posedge clock) disable iff (!resetn)
    byte_evt && !daisy_mode && s.st != st_rd && !timeout
    |=> s.resp == {$past(s.resp[7:0]), FILL_BYTE})
    else $error("response not moved on by one byte");

  rd_load_a: assert property (@(posedge clock) disable iff (!resetn)
    acc_req && !acc_write && acc_hit && !byte_evt && !timeout
    |=> s.resp == {RESP_PAD, $past(acc_rdata)})
    else $error("read value not buffered for output");

  cmd_take_a: assert property (@(posedge clock) disable iff (!resetn)
    byte_evt && daisy_mode && data_ready_n |=> cmd_valid && cmd_byte == $past(b))
    else $error("half duplex command byte not passed on");

  ready_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    !data_ready_n && !s.taken |=> !data_ready_n && s.tx_mode)
    else $error("ready released before the byte was read");

  rd_cov_c: cover property (@(posedge clock) acc_req && !acc_write && acc_hit);
  wr_cov_c: cover property (@(posedge clock) acc_req && acc_write);
  dz_cov_c: cover property (@(posedge clock) $rose(data_ready_n));
  to_cov_c: cover property (@(posedge clock) timeout && s.st != st_first);
  cmd_cov_c: cover property (@(posedge clock) cmd_valid);
endmodule // cell_monitor_spi_host_port

// *** rtl/cell_monitor_spi_pkg.sv ***
package cell_monitor_spi_pkg;
  // Core clock and chip-select-high timeout
  localparam int CLOCK_MHZ = 250;
  localparam int TIMEOUT_US = 100;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLOCK_MHZ;
  localparam int CNT_W = 16;
  // Command byte 0 fields
  localparam int RW_POS = 7;
  localparam int PAGE_MSB = 6;
  localparam int PAGE_LSB = 4;
  localparam int LOC_HI_MSB = 3;
  // Command byte 1 fields
  localparam int LOC_LO_MSB = 7;
  localparam int LOC_LO_LSB = 6;
  localparam int DATA_HI_MSB = 5;
  // Valid page range of the memory map
  localparam logic [2:0] PAGE_FIRST = 3'h1;
  localparam logic [2:0] PAGE_LAST = 3'h5;
  // Reset and default values
  localparam logic [15:0] UNKNOWN_READ = 16'h0000;
  localparam logic [1:0] RESP_PAD = 2'h0;
  localparam logic [7:0] FILL_BYTE = 8'h00;

  typedef enum logic [1:0] {
    st_first = 2'b00,
    st_rd = 2'b01,
    st_wr1 = 2'b10,
    st_wr2 = 2'b11
  } frame_e;

  typedef logic [CNT_W-1:0] cnt_t;
endpackage

// *** verification/cell_monitor_spi_host_port_bench.sv ***
`timescale 1ns/100ps
module cell_monitor_spi_host_port_bench;
  import cell_monitor_spi_pkg::*;
  localparam cnt_t TOC = 16'h0032;
  logic clock, resetn, daisy_mode, acc_hit, rsp_valid, sclk, cs_n, sdi, sdo, sdo_oe;
  logic data_ready_n, acc_req, acc_write, cmd_valid, rsp_ready, taken;
  logic [2:0] acc_page;
  logic [5:0] acc_loc;
  logic [13:0] acc_rdata, acc_wdata;
  logic [7:0] cmd_byte, rsp_byte, rx, last_cmd;
  logic [15:0] pend;
  logic [23:0] last_acc;
  int mismatches, cmp_count, n_acc, n_cmd, nc;

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  cell_monitor_spi_host_port #(.TIMEOUT_CYCLES(TOC)) u_dut (
    .clock(clock), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .data_ready_n(data_ready_n), .daisy_mode(daisy_mode),
    .acc_req(acc_req), .acc_write(acc_write), .acc_page(acc_page), .acc_loc(acc_loc),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_hit(acc_hit),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .rsp_valid(rsp_valid),
    .rsp_byte(rsp_byte), .rsp_ready(rsp_ready));

  spi_host_model u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

  always @(posedge clock)
  begin
    if (acc_req === 1'b1)
    begin
      n_acc++;
      last_acc = {acc_write, acc_page, acc_loc, acc_wdata};
    end
    if (cmd_valid === 1'b1)
    begin
      n_cmd++;
      last_cmd = cmd_byte;
    end
  end

  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One stand-alone command; its first two bytes carry the previous response
  task automatic sa_cmd(logic wr, logic [2:0] pg, logic [5:0] loc, logic [13:0] d, logic hit);
    int na;
    logic ok;
    na = n_acc;
    ok = (pg >= PAGE_FIRST) && (pg <= PAGE_LAST);
    @(posedge clock);
    acc_rdata <= d;
    acc_hit <= hit;
    u_host.xfer({wr, pg, loc[5:2]}, rx);
    check("resp_hi", rx, pend[15:8]);
    u_host.xfer({loc[1:0], wr ? d[13:8] : FILL_BYTE[5:0]}, rx);
    check("resp_lo", rx, pend[7:0]);
    if (wr)
    begin
      u_host.xfer(d[7:0], rx);
      check("wr_third", rx, 0);
    end
    check("acc_count", 24'(n_acc - na), 24'(ok));
    if (ok)
      check("acc_fields", last_acc, {wr, pg, loc, wr ? d : last_acc[13:0]});
    pend = (!wr && ok && hit) ? {RESP_PAD, d} : UNKNOWN_READ;
  endtask

  task automatic daisy_byte(logic [7:0] cb, logic [7:0] rb);
    nc = n_cmd;
    u_host.xfer(cb, rx);
    check("cmd_no_drive", rx, 8'hxx);
    check("cmd_count", 24'(n_cmd - nc), 1);
    check("cmd_byte", last_cmd, cb);
    @(posedge clock);
    rsp_byte <= rb;
    rsp_valid <= 1'b1;
    taken = 1'b0;
    for (int i = 0; i < 40 && !taken; i++)
      @(negedge clock) taken = (rsp_ready === 1'b1);
    @(posedge clock);
    rsp_valid <= 1'b0;
    @(negedge clock);
    check("rsp_taken", taken, 1);
    check("ready_low", data_ready_n, 0);
    nc = n_cmd;
    u_host.xfer(~cb, rx);
    check("rsp_byte", rx, rb);
    check("din_ignored", 24'(n_cmd - nc), 0);
    check("ready_high", data_ready_n, 1);
  endtask

  initial
  begin
    resetn = 1'b0;
    daisy_mode = 1'b0;
    acc_hit = 1'b0;
    rsp_valid = 1'b0;
    acc_rdata = 14'h0000;
    rsp_byte = 8'h00;
    pend = 16'h0000;
    void'($urandom(6));
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    repeat (6) @(posedge clock);
    sa_cmd(1'b0, 3'h3, 6'h08, 14'h2abc, 1'b1);
    sa_cmd(1'b1, 3'h5, 6'h3f, 14'h3fff, 1'b1);
    sa_cmd(1'b0, 3'h1, 6'h00, 14'h1234, 1'b1);
    sa_cmd(1'b0, 3'h0, 6'h01, 14'h1111, 1'b1);
    sa_cmd(1'b0, 3'h6, 6'h02, 14'h0f0f, 1'b1);
    sa_cmd(1'b0, 3'h2, 6'h05, 14'h0777, 1'b0);
    sa_cmd(1'b1, 3'h7, 6'h10, 14'h0123, 1'b1);
    repeat (10) sa_cmd(1'($urandom), 3'($urandom), 6'($urandom), 14'($urandom), 1'($urandom));
    $display("test stand_alone done");
    sa_cmd(1'b0, 3'h2, 6'h11, 14'h0abc, 1'b1);
    u_host.xfer(8'ha0, rx);
    check("part_hi", rx, pend[15:8]);
    repeat (TOC + 10) @(posedge clock);
    check("oe_idle", sdo_oe, 0);
    pend = UNKNOWN_READ;
    sa_cmd(1'b0, 3'h4, 6'h2a, 14'h1555, 1'b1);
    $display("test timeout done");
    @(posedge clock);
    daisy_mode <= 1'b1;
    daisy_byte(8'hff, 8'h00);
    daisy_byte(8'h00, 8'h81);
    repeat (4) daisy_byte(8'($urandom), 8'($urandom));
    $display("test daisy done");
    final_report;
  end

  // Several times the expected run length
  initial
  begin
    #200000;
    mismatches++;
    final_report;
  end
endmodule // cell_monitor_spi_host_port_bench

// *** verification/spi_host_model.sv ***
`timescale 1ns/100ps
module spi_host_model (
  // Serial pins toward the port
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  // Returned data
  input wire logic sdo,
  input wire logic sdo_oe
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Clock runs only inside a frame; odd offset keeps it unrelated to the core clock
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #1.7;
    cs_n = 1'b0;
    #32;
    for (int i = 7; i >= 0; i--)
    begin
      sdi = tx[i];
      #32;
      sclk = 1'b1;
      rx[i] = sdo_oe ? sdo : 1'bx;
      #32;
      sclk = 1'b0;
    end
    cs_n = 1'b1;
    sdi = ~sdi;
    #64;
  endtask
endmodule // spi_host_model
